// file: src/dxc_executor.sv
// Extended-mode command executor: parameters in, seek/verify/find, DMA word moves.
// Assumes host, memory port and formatter all run on ref_clk with valid/ack handshakes.
//
// Notes on behaviour
// - Code 0010 copies the counted words from host memory onto the disk.
// - Code 0011 copies the counted words from disk into host memory.
// - Every direct transfer with a nonzero count, except code 0110 on a fixed unit, seeks, checks the read cylinder, then finds the sector.
// - Position is physical when physical select is 1, else logical.
// - Sixth parameter carries high buffer address only with extended address flag.
// - Running past a cylinder's end steps to the next cylinder automatically.
// - A write ending mid-sector pads the sector with zeros.
// - Direct write ends on error or full count; done, error if faulted.
// - Direct read ends on count exhausted or error; done, error if faulted.
// - Status word is in the data buffer register before done rises.
// - Wrong mode word ends with error and keeps the current mode.
// - Correct mode word enters compatible mode and ends with done.
// - Code 0101 refreshes status, writes the buffer register, then done.
// - Status read never raises the error flag.
// - Code 0110 is a direct write recorded with deleted-data marks; on a fixed unit it ends with a media error.
// - Write data is fetched from host memory starting at the buffer address.
// - Commands behave alike on floppy and fixed units unless stated.
`timescale 1ns/10ps
module dxc_executor
  import dxc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Host command side
  input  wire logic        cmd_valid,
  input  wire logic [3:0]  cmd_code,
  input  wire logic        param_valid,
  input  wire logic [15:0] param_data,
  input  wire logic        physical_address_select,
  input  wire logic        extended_address_flag,
  input  wire logic [3:0]  unit_is_floppy,
  input  wire logic [3:0]  unit_ready,
  output logic             busy,
  output logic             done,
  output logic             error,
  output logic [15:0]      data_buffer_register,
  output logic             compat_mode,
  // Host memory DMA port
  output logic             mem_req,
  output logic             mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [15:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  // Formatter side
  output logic             seek_req,
  output logic [1:0]       seek_unit,
  output dxc_pos_t         seek_pos,
  input  wire logic        seek_ack,
  input  wire logic        seek_fail,
  input  wire logic        id_valid,
  input  wire logic [15:0] id_cyl,
  output logic             find_req,
  input  wire logic        find_ack,
  output logic             dsk_wr_valid,
  output logic [15:0]      dsk_wr_data,
  output logic             dsk_wr_deleted,
  input  wire logic        dsk_wr_ready,
  input  wire logic        dsk_rd_valid,
  input  wire logic [15:0] dsk_rd_data,
  output logic             dsk_rd_ready,
  input  wire logic        dsk_error
);

  // ----------------------------------------------------------------
  // State and working registers
  // ----------------------------------------------------------------
  dxc_state_t        state_r;
  logic [3:0]        code_r;
  logic [2:0]        pidx_r;
  logic [2:0]        pneed_r;
  logic [1:0]        unit_r;
  logic [15:0]       pos_hi_r;
  logic [15:0]       pos_lo_r;
  logic              phys_r;
  logic [15:0]       count_r;
  logic [15:0]       secw_r;
  logic [ADDR_W-1:0] addr_r;
  logic              xa_r;
  logic [15:0]       mode_word_r;
  logic              err_r;
  logic [2:0]        ecode_r;
  logic              compat_r;
  logic [15:0]       dbr_r;
  logic              done_r;
  logic              mem_req_r;
  logic              mem_we_r;
  logic [15:0]       word_r;
  logic              seek_req_r;
  logic              find_req_r;
  logic              dwv_r;
  logic              drr_r;
  logic              busy_r;
  logic              del_r;
  dxc_pos_t          pos_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  dxc_pos_t    pos_map;
  dxc_pos_t    pos_adv;
  dxc_status_t status_now;
  logic        is_write;
  logic        is_direct;
  logic        floppy_sel;
  logic        cmd_take;
  logic        param_take;
  logic        last_param;
  logic        mem_done;
  logic        dwr_done;
  logic        drd_done;
  logic        sec_end;
  logic        count_end;
  logic        fault_in;
  logic        disk_phase;
  logic        head_wrap;
  logic        sec_wrap;

  dxc_pos_map u_pos_map (
    .pos_hi   (pos_hi_r),
    .pos_lo   (pos_lo_r),
    .physical (phys_r),
    .pos      (pos_map)
  );

  assign is_write   = (code_r == CMD_WRITE) || (code_r == CMD_WRITE_DEL);
  assign is_direct  = is_write || (code_r == CMD_READ);
  assign floppy_sel = unit_is_floppy[unit_r];
  assign cmd_take   = (state_r == ST_IDLE) && cmd_valid;
  assign param_take = (state_r == ST_PARAM) && param_valid;
  assign last_param = param_take && (pidx_r + 3'h1 == pneed_r);
  assign mem_done   = mem_req_r && mem_ack;
  assign dwr_done   = dwv_r && dsk_wr_ready;
  assign drd_done   = drr_r && dsk_rd_valid;
  assign sec_end    = (secw_r + ONE_W == SECTOR_WORDS);
  assign count_end  = (count_r == ONE_W);
  assign fault_in   = dsk_error && disk_phase;
  assign disk_phase = (state_r == ST_FIND) || (state_r == ST_MEM) || (state_r == ST_DSK) ||
                      (state_r == ST_FILL) || (state_r == ST_VERIFY);

  // Next sector, head and cylinder in turn
  assign sec_wrap       = (pos_r.sector == SECTORS_PER_TRK + FIRST_SECTOR - ONE_B);
  assign head_wrap      = (pos_r.head + ONE_B == HEADS);
  assign pos_adv.sector = sec_wrap ? FIRST_SECTOR : pos_r.sector + ONE_B;
  assign pos_adv.head   = !sec_wrap ? pos_r.head : (head_wrap ? 8'h00 : pos_r.head + ONE_B);
  assign pos_adv.cyl    = (sec_wrap && head_wrap) ? pos_r.cyl + ONE_W : pos_r.cyl;

  // Status word, refreshed from live inputs each time it is captured
  assign status_now.error       = err_r;
  assign status_now.err_code    = ecode_r;
  assign status_now.compat_mode = compat_r;
  assign status_now.floppy      = floppy_sel;
  assign status_now.ready       = unit_ready[unit_r];
  assign status_now.zero        = 7'h00;
  assign status_now.unit        = unit_r;

  // ----------------------------------------------------------------
  // Command and parameter capture
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      code_r  <= 4'h0;
      pneed_r <= 3'h0;
      pidx_r  <= 3'h0;
      xa_r    <= 1'b0;
      phys_r  <= 1'b0;
      del_r   <= 1'b0;
    end else if (cmd_take) begin
      code_r  <= cmd_code;
      del_r   <= (cmd_code == CMD_WRITE_DEL);
      pidx_r  <= 3'h0;
      xa_r    <= extended_address_flag;
      phys_r  <= physical_address_select;
      if (cmd_code == CMD_WRITE || cmd_code == CMD_READ || cmd_code == CMD_WRITE_DEL) begin
        pneed_r <= extended_address_flag ? NPARAM_DIR_XA : NPARAM_DIRECT;
      end else begin
        pneed_r <= NPARAM_ONE;
      end
    end else if (param_take) begin
      pidx_r <= pidx_r + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      unit_r      <= 2'h0;
      pos_hi_r    <= 16'h0000;
      pos_lo_r    <= 16'h0000;
      mode_word_r <= 16'h0000;
    end else if (param_take) begin
      unique case (pidx_r)
        PIDX_UNIT: begin
          unit_r      <= param_data[1:0];
          mode_word_r <= param_data;
        end
        PIDX_POS_HI: pos_hi_r <= param_data;
        PIDX_POS_LO: pos_lo_r <= param_data;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
      err_r   <= 1'b0;
      ecode_r <= ERR_NONE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (cmd_take) begin
            state_r <= ST_PARAM;
            err_r   <= 1'b0;
            ecode_r <= ERR_NONE;
          end
        end
        ST_PARAM: if (last_param) state_r <= ST_DECODE;
        ST_DECODE: begin
          if (code_r == CMD_STATUS) begin
            state_r <= ST_FINISH;
          end else if (code_r == CMD_SET_MODE) begin
            if (mode_word_r != MODE_WORD_COMPAT) begin
              err_r   <= 1'b1;
              ecode_r <= ERR_MODE;
            end
            state_r <= ST_FINISH;
          end else if (!is_direct) begin
            err_r   <= 1'b1;
            ecode_r <= ERR_CMD;
            state_r <= ST_FINISH;
          end else if (code_r == CMD_WRITE_DEL && !floppy_sel) begin
            err_r   <= 1'b1;
            ecode_r <= ERR_MEDIA;
            state_r <= ST_FINISH;
          end else if (count_r == 16'h0000) begin
            state_r <= ST_FINISH;
          end else begin
            state_r <= ST_SEEK;
          end
        end
        ST_SEEK: begin
          if (seek_req_r && seek_fail) begin
            err_r   <= 1'b1;
            ecode_r <= ERR_SEEK;
            state_r <= ST_FINISH;
          end else if (seek_req_r && seek_ack) begin
            state_r <= ST_VERIFY;
          end
        end
        ST_VERIFY: begin
          if (fault_in) begin
            err_r   <= 1'b1;
            ecode_r <= ERR_DISK;
            state_r <= ST_FINISH;
          end else if (id_valid && id_cyl != pos_r.cyl) begin
            err_r   <= 1'b1;
            ecode_r <= ERR_CYL;
            state_r <= ST_FINISH;
          end else if (id_valid) begin
            state_r <= ST_FIND;
          end
        end
        ST_FIND: begin
          if (fault_in) begin
            err_r   <= 1'b1;
            ecode_r <= ERR_DISK;
            state_r <= ST_FINISH;
          end else if (find_req_r && find_ack) begin
            state_r <= is_write ? ST_MEM : ST_DSK;
          end
        end
        ST_MEM, ST_DSK, ST_FILL: begin
          if (fault_in) begin
            err_r   <= 1'b1;
            ecode_r <= ERR_DISK;
            state_r <= ST_FINISH;
          end else if (state_r == ST_MEM && mem_done) begin
            if (is_write) begin
              state_r <= ST_DSK;
            end else if (count_end) begin
              state_r <= ST_FINISH;
            end else begin
              state_r <= sec_end ? ST_NEXT : ST_DSK;
            end
          end else if (state_r == ST_DSK && drd_done) begin
            state_r <= ST_MEM;
          end else if ((state_r == ST_DSK && dwr_done) || (state_r == ST_FILL && dwr_done)) begin
            if (sec_end) begin
              state_r <= (count_end || state_r == ST_FILL) ? ST_FINISH : ST_NEXT;
            end else if (state_r == ST_DSK && count_end) begin
              state_r <= ST_FILL;
            end else if (state_r == ST_DSK) begin
              state_r <= ST_MEM;
            end
          end
        end
        ST_NEXT: state_r <= (pos_adv.cyl != pos_r.cyl) ? ST_SEEK : ST_FIND;
        ST_FINISH: state_r <= ST_DONE;
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Position, counts and buffer address
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pos_r   <= '0;
      count_r <= 16'h0000;
      secw_r  <= 16'h0000;
      addr_r  <= '0;
    end else begin
      if (param_take && pidx_r == PIDX_COUNT) count_r <= param_data;
      if (param_take && pidx_r == PIDX_BUF_LO) addr_r[15:0] <= param_data;
      if (param_take && pidx_r == PIDX_BUF_LO && !xa_r) addr_r[ADDR_W-1:16] <= '0;
      if (param_take && pidx_r == PIDX_BUF_HI) addr_r[ADDR_W-1:16] <= param_data[BUF_HI_W-1:0];
      if (state_r == ST_DECODE) begin
        pos_r  <= pos_map;
        secw_r <= 16'h0000;
      end
      if (state_r == ST_NEXT) begin
        pos_r  <= pos_adv;
        secw_r <= 16'h0000;
      end
      if (mem_done) addr_r <= addr_r + ONE_A;
      if ((mem_done && !is_write) || (dwr_done && state_r == ST_DSK)) begin
        count_r <= count_r - ONE_W;
        secw_r  <= secw_r + ONE_W;
      end
      if (dwr_done && state_r == ST_FILL) secw_r <= secw_r + ONE_W;
    end
  end

  // ----------------------------------------------------------------
  // Handshake outputs toward memory and formatter
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mem_req_r  <= 1'b0;
      mem_we_r   <= 1'b0;
      seek_req_r <= 1'b0;
      find_req_r <= 1'b0;
      dwv_r      <= 1'b0;
      drr_r      <= 1'b0;
      word_r     <= 16'h0000;
    end else begin
      mem_req_r  <= (state_r == ST_MEM) && !mem_done && !fault_in;
      mem_we_r   <= !is_write;
      seek_req_r <= (state_r == ST_SEEK) && !(seek_req_r && (seek_ack || seek_fail));
      find_req_r <= (state_r == ST_FIND) && !(find_req_r && find_ack) && !fault_in;
      dwv_r      <= ((state_r == ST_DSK && is_write) || state_r == ST_FILL) && !dwr_done && !fault_in;
      drr_r      <= (state_r == ST_DSK && !is_write) && !drd_done && !fault_in;
      if (mem_done && is_write) word_r <= mem_rdata;
      if (drd_done) word_r <= dsk_rd_data;
      if (state_r == ST_FILL) word_r <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Completion, status word and mode
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dbr_r    <= 16'h0000;
      done_r   <= 1'b0;
      busy_r   <= 1'b0;
      compat_r <= 1'b0;
    end else begin
      if (state_r == ST_DECODE && code_r == CMD_SET_MODE && mode_word_r == MODE_WORD_COMPAT) begin
        compat_r <= 1'b1;
      end
      if (state_r == ST_FINISH) dbr_r <= status_now;
      if (cmd_take) begin
        done_r <= 1'b0;
        busy_r <= 1'b1;
      end else if (state_r == ST_DONE) begin
        done_r <= 1'b1;
        busy_r <= 1'b0;
      end
    end
  end

  assign busy                 = busy_r;
  assign done                 = done_r;
  assign error                = dbr_r[15];
  assign data_buffer_register = dbr_r;
  assign compat_mode          = compat_r;
  assign mem_req              = mem_req_r;
  assign mem_we               = mem_we_r;
  assign mem_addr             = addr_r;
  assign mem_wdata            = word_r;
  assign seek_req             = seek_req_r;
  assign seek_unit            = unit_r;
  assign seek_pos             = pos_r;
  assign find_req             = find_req_r;
  assign dsk_wr_valid         = dwv_r;
  assign dsk_wr_data          = word_r;
  assign dsk_wr_deleted       = del_r;
  assign dsk_rd_ready         = drr_r;

endmodule : dxc_executor

// file: src/dxc_pkg.sv
// Constants, field layouts and carrier types of the extended command executor.
// Assumes one 125 MHz clock domain shared with the host-side command logic.
package dxc_pkg;

  // ----------------------------------------------------------------
  // Command codes and parameter counts
  // ----------------------------------------------------------------
  localparam logic [3:0]  CMD_WRITE       = 4'h2;
  localparam logic [3:0]  CMD_READ        = 4'h3;
  localparam logic [3:0]  CMD_SET_MODE    = 4'h4;
  localparam logic [3:0]  CMD_STATUS      = 4'h5;
  localparam logic [3:0]  CMD_WRITE_DEL   = 4'h6;

  localparam logic [2:0]  NPARAM_ONE      = 3'h1;
  localparam logic [2:0]  NPARAM_DIRECT   = 3'h5;
  localparam logic [2:0]  NPARAM_DIR_XA   = 3'h6;

  localparam logic [2:0]  PIDX_UNIT       = 3'h0;
  localparam logic [2:0]  PIDX_POS_HI     = 3'h1;
  localparam logic [2:0]  PIDX_POS_LO     = 3'h2;
  localparam logic [2:0]  PIDX_COUNT      = 3'h3;
  localparam logic [2:0]  PIDX_BUF_LO     = 3'h4;
  localparam logic [2:0]  PIDX_BUF_HI     = 3'h5;

  // Required value of the mode word (plain default)
  localparam logic [15:0] MODE_WORD_COMPAT = 16'h0001;

  // ----------------------------------------------------------------
  // Geometry and widths
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 22;
  localparam int          BUF_HI_W        = 6;
  localparam logic [15:0] SECTOR_WORDS    = 16'h0100;
  localparam logic [7:0]  SECTORS_PER_TRK = 8'h1A;
  localparam logic [7:0]  HEADS           = 8'h02;
  localparam logic [7:0]  FIRST_SECTOR    = 8'h01;
  localparam logic [15:0] ONE_W           = 16'h0001;
  localparam logic [7:0]  ONE_B           = 8'h01;
  localparam logic [ADDR_W-1:0] ONE_A     = 22'h00_0001;

  // ----------------------------------------------------------------
  // Error codes
  // ----------------------------------------------------------------
  localparam logic [2:0]  ERR_NONE        = 3'h0;
  localparam logic [2:0]  ERR_SEEK        = 3'h1;
  localparam logic [2:0]  ERR_CYL         = 3'h2;
  localparam logic [2:0]  ERR_DISK        = 3'h3;
  localparam logic [2:0]  ERR_MODE        = 3'h4;
  localparam logic [2:0]  ERR_CMD         = 3'h5;
  localparam logic [2:0]  ERR_MEDIA       = 3'h6;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cyl;
    logic [7:0]  head;
    logic [7:0]  sector;
  } dxc_pos_t;

  typedef struct packed {
    logic       error;
    logic [2:0] err_code;
    logic       compat_mode;
    logic       floppy;
    logic       ready;
    logic [6:0] zero;
    logic [1:0] unit;
  } dxc_status_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_PARAM  = 4'b0001,
    ST_DECODE = 4'b0010,
    ST_SEEK   = 4'b0011,
    ST_VERIFY = 4'b0100,
    ST_FIND   = 4'b0101,
    ST_MEM    = 4'b0110,
    ST_DSK    = 4'b0111,
    ST_FILL   = 4'b1000,
    ST_NEXT   = 4'b1001,
    ST_FINISH = 4'b1010,
    ST_DONE   = 4'b1011
  } dxc_state_t;

endpackage : dxc_pkg

// file: src/dxc_pos_map.sv
// Disk position decoder: turns the two position words into cylinder/head/sector.
// Assumes the caller registers the result; purely combinational.
`timescale 1ns/10ps
module dxc_pos_map
  import dxc_pkg::*;
(
  input  wire logic [15:0] pos_hi,
  input  wire logic [15:0] pos_lo,
  input  wire logic        physical,
  output dxc_pos_t         pos
);

  // ----------------------------------------------------------------
  // Logical block split
  // ----------------------------------------------------------------
  logic [31:0] lba;
  logic [31:0] track;
  logic [31:0] sec_idx;
  logic [31:0] head_idx;
  logic [31:0] cyl_idx;

  assign lba      = {pos_hi, pos_lo};
  assign track    = lba / {24'h00_0000, SECTORS_PER_TRK};
  assign sec_idx  = lba % {24'h00_0000, SECTORS_PER_TRK};
  assign head_idx = track % {24'h00_0000, HEADS};
  assign cyl_idx  = track / {24'h00_0000, HEADS};

  // Physical: high word cylinder, low word head and sector
  assign pos.cyl    = physical ? pos_hi       : cyl_idx[15:0];
  assign pos.head   = physical ? pos_lo[15:8] : head_idx[7:0];
  assign pos.sector = physical ? pos_lo[7:0]  : sec_idx[7:0] + FIRST_SECTOR;

endmodule : dxc_pos_map

// file: sim/dxc_executor_chk.sv
// Checker of the executor's host, DMA and formatter ports.
// Assumes it is bound to dxc_executor; one ref_clk domain.
`timescale 1ns/10ps
module dxc_executor_chk
  import dxc_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              reset,
  input wire logic              cmd_valid,
  input wire logic [3:0]        cmd_code,
  input wire logic              busy,
  input wire logic              done,
  input wire logic              error,
  input wire logic [15:0]       data_buffer_register,
  input wire logic              compat_mode,
  input wire logic              mem_req,
  input wire logic              mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              mem_ack,
  input wire logic [3:0]        unit_is_floppy,
  input wire logic [1:0]        seek_unit,
  input wire logic              dsk_wr_valid,
  input wire logic              dsk_wr_deleted
);
  logic [3:0] code_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) code_r <= 4'h0;
    else if (cmd_valid && !busy) code_r <= cmd_code;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  dbr_hold_a: assert property (done && !cmd_valid |=> $stable(data_buffer_register)) else $error("status moved");
  dbr_first_a: assert property ($rose(done) |-> $stable(data_buffer_register)) else $error("status late");
  stat_noerr_a: assert property ($rose(done) && code_r == CMD_STATUS |-> !error) else $error("status error");
  mode_only_a: assert property ($changed(compat_mode) |-> code_r == CMD_SET_MODE) else $error("mode moved");
  rd_dir_a: assert property (mem_req && mem_we |-> code_r == CMD_READ) else $error("memory write");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)) else $error("req");
  mem_drop_a: assert property (mem_req && mem_ack |=> !mem_req) else $error("req kept");
  del_fixed_a: assert property (dsk_wr_valid && dsk_wr_deleted |-> unit_is_floppy[seek_unit]
    && code_r == CMD_WRITE_DEL) else $error("deleted mark");
  done_idle_a: assert property (done |-> !busy) else $error("done while busy");
  take_busy_a: assert property (cmd_valid && !busy |=> busy) else $error("cmd not taken");
  cover property ($rose(done) && error);
  cover property (dsk_wr_valid && dsk_wr_deleted);
  cover property ($rose(compat_mode));
endmodule : dxc_executor_chk
bind dxc_executor dxc_executor_chk chk_i (.ref_clk, .reset, .cmd_valid, .cmd_code, .busy, .done, .error,
  .data_buffer_register, .compat_mode, .mem_req, .mem_we, .mem_addr, .mem_ack, .unit_is_floppy,
  .seek_unit, .dsk_wr_valid, .dsk_wr_deleted);

// file: sim/dxc_far_model.sv
// Far side: host memory plus disk formatter; acks and write ready every other cycle, read data and ID always valid.
// Assumes ref_clk domain; fail_seek comes from the bench.
`timescale 1ns/10ps
module dxc_far_model
  import dxc_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              reset,
  input wire logic              fail_seek,
  input wire logic              mem_req,
  input wire logic [ADDR_W-1:0] mem_addr,
  output logic                  mem_ack,
  output logic [15:0]           mem_rdata,
  input wire logic              seek_req,
  input wire dxc_pos_t          seek_pos,
  output logic                  seek_ack,
  output logic                  seek_fail,
  output logic                  id_valid,
  output logic [15:0]           id_cyl,
  input wire logic              find_req,
  output logic                  find_ack,
  output logic                  dsk_wr_ready,
  output logic                  dsk_rd_valid,
  output logic [15:0]           dsk_rd_data,
  input wire logic              dsk_rd_ready
);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      {mem_ack, seek_ack, seek_fail, id_valid, find_ack, dsk_wr_ready, dsk_rd_valid} <= '0;
      {mem_rdata, id_cyl, dsk_rd_data} <= '0;
    end else begin
      mem_ack <= mem_req & ~mem_ack;
      // Data only valid with ack; garbage otherwise
      mem_rdata <= (mem_req & ~mem_ack) ? (mem_addr[15:0] ^ 16'hA5A5) : ~mem_rdata;
      seek_ack <= seek_req & ~seek_ack & ~fail_seek;
      seek_fail <= seek_req & ~seek_fail & fail_seek;
      // Cylinder 255 reads back one too high
      if (seek_req) id_cyl <= seek_pos.cyl + {15'h0000, &seek_pos.cyl[7:0]};
      id_valid <= 1'b1;
      find_ack <= find_req & ~find_ack;
      dsk_wr_ready <= ~dsk_wr_ready;
      dsk_rd_valid <= 1'b1;
      if (dsk_rd_valid && dsk_rd_ready) dsk_rd_data <= dsk_rd_data + 16'h0001;
    end
  end
endmodule : dxc_far_model

// file: sim/tb.sv
// Testbench: host command sequences against the far-side model.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/10ps
module tb;
  import dxc_pkg::*;
  logic ref_clk, reset, cmd_valid, param_valid, physical_address_select, extended_address_flag, fail_seek;
  logic dsk_error, busy, done, error, compat_mode, mem_req, mem_we, mem_ack, seek_req, seek_ack, seek_fail;
  logic id_valid, find_req, find_ack, dsk_wr_valid, dsk_wr_deleted, dsk_wr_ready, dsk_rd_valid, dsk_rd_ready;
  logic [3:0] cmd_code, unit_is_floppy, unit_ready;
  logic [15:0] param_data, data_buffer_register, mem_wdata, mem_rdata, id_cyl, dsk_wr_data, dsk_rd_data, cyl_l;
  logic [ADDR_W-1:0] mem_addr, a0;
  logic [1:0] seek_unit;
  dxc_pos_t seek_pos;
  logic [15:0] p [6];
  logic s_q;
  int err_total = 0, comparisons = 0, cyc = 0, n_mem, n_wr, n_nz, n_del, n_sk;
  dxc_executor dxc_executor_i (.*);
  dxc_far_model dxc_far_model_i (.*);
  initial begin ref_clk = 1'b0; forever #4 ref_clk = ~ref_clk; end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin err_total++; end_sim; end
    if (mem_req && mem_ack) begin if (n_mem == 0) a0 <= mem_addr; n_mem <= n_mem + 1; end
    if (dsk_wr_valid && dsk_wr_ready) begin
      n_wr <= n_wr + 1; n_nz <= n_nz + (dsk_wr_data !== 16'h0000); n_del <= n_del + dsk_wr_deleted;
    end
    if (seek_req && !s_q) begin n_sk <= n_sk + 1; cyl_l <= seek_pos.cyl; end
    s_q <= seek_req;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin err_total++; $display("wrong value at %0t: got %h exp %h", $time, seen, exp); end
  endtask : chk
  task run(input logic [3:0] c, input logic ph, input logic xf, input int n);
    int k;
    {n_mem, n_wr, n_nz, n_del, n_sk} = '0;
    cmd_code = c; physical_address_select = ph; extended_address_flag = xf; cmd_valid = 1'b1;
    @(posedge ref_clk) #1 cmd_valid = 1'b0;
    for (k = 0; k < n; k++) begin param_valid = 1'b1; param_data = p[k]; @(posedge ref_clk) #1; end
    param_valid = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 20000) begin @(posedge ref_clk) #1; k++; end
    chk(done, 1'b1);
  endtask : run
  task end_sim;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial begin
    reset = 1'b1; {cmd_valid, param_valid, physical_address_select, extended_address_flag} = '0;
    {fail_seek, dsk_error} = '0; cmd_code = 4'h0; param_data = 16'h0000;
    unit_is_floppy = 4'h3; unit_ready = 4'hD;
    repeat (5) @(posedge ref_clk);
    #1 reset = 1'b0;
    p = '{16'h0000, 16'h0007, 16'h0001, 16'h0003, 16'h0100, 16'h0000};
    run(CMD_WRITE, 1'b1, 1'b0, 5);
    chk(error, 1'b0); chk(n_sk, 1); chk(cyl_l, 16'h0007);
    chk(a0, 22'h00_0100); chk(n_mem, 3); chk(n_wr, 256); chk(n_nz, 3);
    p = '{16'h0000, 16'h0005, 16'h011A, 16'h0101, 16'h2000, 16'h0002};
    run(CMD_READ, 1'b1, 1'b1, 6);
    chk(error, 1'b0); chk(a0, 22'h02_2000); chk(n_mem, 257);
    chk(n_sk, 2); chk(cyl_l, 16'h0006);
    p = '{16'h0000, 16'h0000, 16'h0034, 16'h0001, 16'h3000, 16'h0000};
    run(CMD_READ, 1'b0, 1'b0, 5);
    chk(cyl_l, 16'h0001);
    p[2] = 16'h0001;
    run(CMD_WRITE_DEL, 1'b1, 1'b0, 5);
    chk(error, 1'b0); chk(n_del != 0, 1'b1); chk(n_wr, 256);
    p[0] = 16'h0002;
    run(CMD_WRITE_DEL, 1'b1, 1'b0, 5);
    chk(error, 1'b1); chk(data_buffer_register[14:12], ERR_MEDIA); chk(n_del, 0);
    run(CMD_WRITE, 1'b1, 1'b0, 5);
    chk(error, 1'b0); chk(n_wr, 256);
    p[1] = 16'h00FF;
    run(CMD_WRITE, 1'b1, 1'b0, 5);
    chk(data_buffer_register[14:12], ERR_CYL); chk(n_mem, 0);
    p[0] = 16'h0000; fail_seek = 1'b1;
    run(CMD_WRITE, 1'b1, 1'b0, 5);
    chk(error, 1'b1); chk(data_buffer_register[14:12], ERR_SEEK); chk(n_mem, 0);
    fail_seek = 1'b0; dsk_error = 1'b1;
    run(CMD_READ, 1'b1, 1'b0, 5);
    chk(error, 1'b1);
    dsk_error = 1'b0; p[0] = 16'h0001;
    run(CMD_STATUS, 1'b0, 1'b0, 1);
    chk(data_buffer_register, 16'h0401);
    p[0] = 16'h0002;
    run(CMD_STATUS, 1'b0, 1'b0, 1);
    chk(data_buffer_register, 16'h0202);
    run(CMD_SET_MODE, 1'b0, 1'b0, 1);
    chk(error, 1'b1); chk(data_buffer_register[14:12], ERR_MODE); chk(compat_mode, 1'b0);
    p[0] = MODE_WORD_COMPAT;
    run(CMD_SET_MODE, 1'b0, 1'b0, 1);
    chk(error, 1'b0); chk(compat_mode, 1'b1);
    end_sim;
  end
endmodule : tb
